// ### src/cbfe_core.sv
// Notes on behaviour
// RL1 - Branch when overflow clear; 1/2 cycles
// RL2 - Branch when interrupts enabled; 1/2 cycles
// RL3 - Branch when interrupts disabled; flags kept
// RL4 - IO bit set, others kept, 2 cycles
// RL5 - IO bit clear, others kept, 2 cycles
// RL6 - Shift left, zero in, ZCNV updated
// RL7 - Shift right, zero in, ZCNV updated
// RL8 - Rotate left through carry, one cycle
// RL9 - Rotate right through carry, one cycle
// RL10 - Arithmetic shift right keeps sign bit
// RL11 - Copy register bit into T flag
// RL12 - Copy T flag into register bit
// RL13 - Set and clear signed flag only
// RL14 - Set and clear overflow flag only
// RL15 - Set and clear half carry only
// RL16 - Load through X then increment X
// RL17 - Decrement X then load through X
// RL18 - Y loads: plain, increment, decrement forms
// RL19 - Load Y plus displacement, Y unchanged
// RL20 - Swap nibbles, flags kept, one cycle
// RL21 - Copy, pair copy, constant: one cycle
// RL22 - Set or clear C,N,Z,T,I individually
`timescale 1ns/1ps
`include "cbfe_params.svh"

module cbfe_core #(
	parameter int PC_W = `CBFE_PC_W
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               cmd_valid,
	input  wire cbfe_pkg::cbfe_op_e cmd_op,
	input  wire logic [4:0]         cmd_rd,
	input  wire logic [4:0]         cmd_rr,
	input  wire logic [2:0]         cmd_bit,
	input  wire logic [7:0]         cmd_imm,
	input  wire logic [6:0]         cmd_k,
	input  wire logic [5:0]         cmd_q,
	input  wire logic [4:0]         cmd_io,
	input  wire logic [7:0]         mem_rdata,
	input  wire logic [7:0]         io_rdata,
	input  wire logic [4:0]         dbg_sel,
	output logic                    busy,
	output logic                    done,
	output logic [15:0]             pc,
	output logic [7:0]              status_register,
	output logic [15:0]             mem_addr,
	output logic                    mem_rd,
	output logic [4:0]              io_addr,
	output logic                    io_rd,
	output logic                    io_wr,
	output logic [7:0]              io_wdata,
	output logic [7:0]              dbg_val
);
	import cbfe_pkg::*;

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	if (PC_W != 16) begin : g_bad_pc_w
		$error("cbfe_core: only a 16-bit program counter is supported");
	end

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rst_sync_n;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync_q[1];

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	cbfe_state_s s_q;
	cbfe_state_s s_d;
	logic        accept;
	logic [15:0] br_target;

	assign accept    = cmd_valid && !s_q.busy;
	// Offset is signed; target wraps modulo the program space
	assign br_target = s_q.pc + {{9{cmd_k[6]}}, cmd_k} + 16'h0001;

	always_comb begin
		logic [7:0]  a;
		logic [7:0]  r;
		logic        c;
		logic [15:0] ptr;
		logic [4:0]  plo;
		a   = s_q.rf[cmd_rd];
		r   = 8'h00;
		c   = 1'b0;
		ptr = 16'h0000;
		plo = `CBFE_PTR_X_LO;
		s_d = s_q;
		s_d.done    = 1'b0;
		s_d.mem_rd  = 1'b0;
		s_d.io_rd   = 1'b0;
		s_d.io_wr   = 1'b0;
		s_d.reg_val = s_q.rf[dbg_sel];
		case (s_q.st)
			CBFE_ST_IDLE: begin
				if (accept) begin
					s_d.op   = cmd_op;
					s_d.rd   = cmd_rd;
					s_d.bsel = cmd_bit;
					s_d.pc   = s_q.pc + 16'h0001;
					s_d.done = 1'b1;
					case (cmd_op)
						CBFE_OP_BR_NO_OVF, CBFE_OP_BR_IRQ_ON, CBFE_OP_BR_IRQ_OFF: begin
							// A taken branch spends a second cycle busy
							if ((cmd_op == CBFE_OP_BR_NO_OVF && !s_q.status_register[`CBFE_FLAG_V]) ||
							    (cmd_op == CBFE_OP_BR_IRQ_ON && s_q.status_register[`CBFE_FLAG_I]) ||
							    (cmd_op == CBFE_OP_BR_IRQ_OFF && !s_q.status_register[`CBFE_FLAG_I])) begin
								s_d.pc   = br_target; // RL1 RL2 RL3
								s_d.st   = CBFE_ST_FINAL;
								s_d.busy = 1'b1;
								s_d.done = 1'b0;
							end
						end
						CBFE_OP_IO_SET, CBFE_OP_IO_CLR: begin
							// Read-modify-write keeps the other bits of the port
							s_d.io_addr = cmd_io;
							s_d.io_rd   = 1'b1;
							s_d.st      = CBFE_ST_FINAL;
							s_d.busy    = 1'b1;
							s_d.done    = 1'b0;
						end
						CBFE_OP_SHL, CBFE_OP_SHR, CBFE_OP_ROL, CBFE_OP_ROR, CBFE_OP_ASR: begin
							case (cmd_op)
								CBFE_OP_SHL: begin
									r = {a[6:0], 1'b0}; // RL6
									c = a[7];
								end
								CBFE_OP_SHR: begin
									r = {1'b0, a[7:1]}; // RL7
									c = a[0];
								end
								CBFE_OP_ROL: begin
									r = {a[6:0], s_q.status_register[`CBFE_FLAG_C]}; // RL8
									c = a[7];
								end
								CBFE_OP_ROR: begin
									r = {s_q.status_register[`CBFE_FLAG_C], a[7:1]}; // RL9
									c = a[0];
								end
								default: begin
									r = {a[7], a[7:1]}; // RL10
									c = a[0];
								end
							endcase
							s_d.rf[cmd_rd]           = r;
							s_d.status_register[`CBFE_FLAG_C]   = c;
							s_d.status_register[`CBFE_FLAG_N]   = r[7];
							s_d.status_register[`CBFE_FLAG_V]   = r[7] ^ c;
							s_d.status_register[`CBFE_FLAG_Z]   = (r == 8'h00);
						end
						CBFE_OP_SWAP: begin
							s_d.rf[cmd_rd] = {a[3:0], a[7:4]}; // RL20
						end
						CBFE_OP_BIT_TO_T: begin
							s_d.status_register[`CBFE_FLAG_T] = s_q.rf[cmd_rr][cmd_bit]; // RL11
						end
						CBFE_OP_T_TO_BIT: begin
							s_d.rf[cmd_rd][cmd_bit] = s_q.status_register[`CBFE_FLAG_T]; // RL12
						end
						CBFE_OP_FLAG_SET: begin
							s_d.status_register[cmd_bit] = 1'b1; // RL13 RL14 RL15 RL22
						end
						CBFE_OP_FLAG_CLR: begin
							s_d.status_register[cmd_bit] = 1'b0; // RL13 RL14 RL15 RL22
						end
						CBFE_OP_COPY: begin
							s_d.rf[cmd_rd] = s_q.rf[cmd_rr]; // RL21
						end
						CBFE_OP_PAIR_COPY: begin
							// Pairs are even-aligned; the low index bit is ignored
							s_d.rf[{cmd_rd[4:1], 1'b0}] = s_q.rf[{cmd_rr[4:1], 1'b0}]; // RL21
							s_d.rf[{cmd_rd[4:1], 1'b1}] = s_q.rf[{cmd_rr[4:1], 1'b1}];
						end
						CBFE_OP_LOAD_CONST: begin
							// Only the upper sixteen registers take a constant
							s_d.rf[cmd_rd | `CBFE_LDI_BASE] = cmd_imm; // RL21
						end
						CBFE_OP_LD_X, CBFE_OP_LD_X_INC, CBFE_OP_LD_X_DEC,
						CBFE_OP_LD_Y, CBFE_OP_LD_Y_INC, CBFE_OP_LD_Y_DEC,
						CBFE_OP_LD_Y_DISP: begin
							if (cmd_op >= CBFE_OP_LD_Y) begin
								plo = `CBFE_PTR_Y_LO;
							end
							ptr = {s_q.rf[plo + 5'h01], s_q.rf[plo]};
							if (cmd_op == CBFE_OP_LD_X_DEC || cmd_op == CBFE_OP_LD_Y_DEC) begin
								ptr                 = ptr - 16'h0001; // RL17 RL18
								s_d.rf[plo]         = ptr[7:0];
								s_d.rf[plo + 5'h01] = ptr[15:8];
							end else if (cmd_op == CBFE_OP_LD_Y_DISP) begin
								ptr = ptr + {10'h000, cmd_q}; // RL19
							end
							s_d.mem_addr = ptr;
							s_d.mem_rd   = 1'b1;
							s_d.st       = CBFE_ST_FINAL;
							s_d.busy     = 1'b1;
							s_d.done     = 1'b0;
						end
						default: begin
						end
					endcase
				end
			end
			CBFE_ST_FINAL: begin
				s_d.st   = CBFE_ST_IDLE;
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				case (s_q.op)
					CBFE_OP_IO_SET: begin
						s_d.io_wdata           = io_rdata;
						s_d.io_wdata[s_q.bsel] = 1'b1; // RL4
						s_d.io_wr              = 1'b1;
					end
					CBFE_OP_IO_CLR: begin
						s_d.io_wdata           = io_rdata;
						s_d.io_wdata[s_q.bsel] = 1'b0; // RL5
						s_d.io_wr              = 1'b1;
					end
					CBFE_OP_LD_X, CBFE_OP_LD_X_INC, CBFE_OP_LD_X_DEC,
					CBFE_OP_LD_Y, CBFE_OP_LD_Y_INC, CBFE_OP_LD_Y_DEC,
					CBFE_OP_LD_Y_DISP: begin
						s_d.rf[s_q.rd] = mem_rdata; // RL16 RL18 RL19
						if (s_q.op == CBFE_OP_LD_X_INC || s_q.op == CBFE_OP_LD_Y_INC) begin
							plo = (s_q.op == CBFE_OP_LD_Y_INC) ? `CBFE_PTR_Y_LO : `CBFE_PTR_X_LO;
							// Increment follows the read, from the issued address
							ptr                 = s_q.mem_addr + 16'h0001; // RL16 RL18
							s_d.rf[plo]         = ptr[7:0];
							s_d.rf[plo + 5'h01] = ptr[15:8];
						end
					end
					default: begin
					end
				endcase
			end
			default: begin
				s_d.st   = CBFE_ST_IDLE;
				s_d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_q          <= '0;
			s_q.status_register     <= `CBFE_STATUS_REGISTER_RST;
			s_q.rf       <= {32{`CBFE_REG_RST}};
		end else begin
			s_q <= s_d;
		end
	end

	assign busy     = s_q.busy;
	assign done     = s_q.done;
	assign pc       = s_q.pc;
	assign status_register     = s_q.status_register;
	assign mem_addr = s_q.mem_addr;
	assign mem_rd   = s_q.mem_rd;
	assign io_addr  = s_q.io_addr;
	assign io_rd    = s_q.io_rd;
	assign io_wr    = s_q.io_wr;
	assign io_wdata = s_q.io_wdata;
	assign dbg_val  = s_q.reg_val;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_sync_n);

	sequence io_rmw_s(logic want);
		io_rd ##1 (io_wr && done && io_wdata[$past(s_q.bsel)] == want);
	endsequence

	br_no_ovf_a: assert property ( // RL1
		accept && cmd_op == CBFE_OP_BR_NO_OVF && !status_register[`CBFE_FLAG_V]
		|=> pc == $past(br_target) && busy ##1 done && !busy)
		else $error("taken branch on clear overflow wrong");

	br_irq_on_a: assert property ( // RL2
		accept && cmd_op == CBFE_OP_BR_IRQ_ON && !status_register[`CBFE_FLAG_I]
		|=> pc == $past(pc) + 16'h0001 && done && !busy)
		else $error("untaken branch on irq enabled wrong");

	br_irq_off_a: assert property ( // RL3
		accept && cmd_op == CBFE_OP_BR_IRQ_OFF && !status_register[`CBFE_FLAG_I]
		|=> pc == $past(br_target) && $stable(status_register))
		else $error("branch on irq disabled wrong");

	io_set_a: assert property ( // RL4
		accept && cmd_op == CBFE_OP_IO_SET |=> io_rmw_s(1'b1))
		else $error("io bit set sequence wrong");

	io_clr_a: assert property ( // RL5
		accept && cmd_op == CBFE_OP_IO_CLR |=> io_rmw_s(1'b0))
		else $error("io bit clear sequence wrong");

	shl_flags_a: assert property ( // RL6
		accept && cmd_op == CBFE_OP_SHL
		|=> status_register[`CBFE_FLAG_C] == $past(s_q.rf[cmd_rd][7]) &&
		    s_q.rf[$past(cmd_rd)] == {$past(s_q.rf[cmd_rd][6:0]), 1'b0} && done)
		else $error("shift left result or carry wrong");

	ror_carry_a: assert property ( // RL9
		accept && cmd_op == CBFE_OP_ROR
		|=> s_q.rf[$past(cmd_rd)][7] == $past(status_register[`CBFE_FLAG_C]) &&
		    status_register[`CBFE_FLAG_C] == $past(s_q.rf[cmd_rd][0]))
		else $error("rotate right through carry wrong");

	ld_x_inc_a: assert property ( // RL16
		accept && cmd_op == CBFE_OP_LD_X_INC && cmd_rd < `CBFE_PTR_X_LO
		|=> mem_rd && mem_addr == $past({s_q.rf[27], s_q.rf[26]})
		##1 done && {s_q.rf[27], s_q.rf[26]} == $past(mem_addr) + 16'h0001)
		else $error("post-increment load through X wrong");

	ld_y_disp_a: assert property ( // RL19
		accept && cmd_op == CBFE_OP_LD_Y_DISP && cmd_rd < `CBFE_PTR_X_LO
		|=> mem_addr == $past({s_q.rf[29], s_q.rf[28]} + {10'h000, cmd_q})
		##1 $stable({s_q.rf[29], s_q.rf[28]}))
		else $error("displaced load address or pointer wrong");

endmodule // cbfe_core

// ### src/cbfe_params.svh
`ifndef CBFE_PARAMS_SVH
`define CBFE_PARAMS_SVH

// ------------------------------------------------------------------
// Status register bit positions
// ------------------------------------------------------------------
`define CBFE_FLAG_C 3'h0
`define CBFE_FLAG_Z 3'h1
`define CBFE_FLAG_N 3'h2
`define CBFE_FLAG_V 3'h3
`define CBFE_FLAG_S 3'h4
`define CBFE_FLAG_H 3'h5
`define CBFE_FLAG_T 3'h6
`define CBFE_FLAG_I 3'h7

// ------------------------------------------------------------------
// Pointer register pairs (low byte index)
// ------------------------------------------------------------------
`define CBFE_PTR_X_LO 5'h1a
`define CBFE_PTR_Y_LO 5'h1c

// ------------------------------------------------------------------
// Reset values and field widths
// ------------------------------------------------------------------
`define CBFE_STATUS_REGISTER_RST 8'h00
`define CBFE_REG_RST  8'h00
`define CBFE_PC_W     16
`define CBFE_LDI_BASE 5'h10

`endif

// ### src/cbfe_pkg.sv
package cbfe_pkg;

	typedef enum logic [4:0] {
		CBFE_OP_NOP        = 5'h00,
		CBFE_OP_BR_NO_OVF  = 5'h01,
		CBFE_OP_BR_IRQ_ON  = 5'h02,
		CBFE_OP_BR_IRQ_OFF = 5'h03,
		CBFE_OP_IO_SET     = 5'h04,
		CBFE_OP_IO_CLR     = 5'h05,
		CBFE_OP_SHL        = 5'h06,
		CBFE_OP_SHR        = 5'h07,
		CBFE_OP_ROL        = 5'h08,
		CBFE_OP_ROR        = 5'h09,
		CBFE_OP_ASR        = 5'h0a,
		CBFE_OP_SWAP       = 5'h0b,
		CBFE_OP_BIT_TO_T   = 5'h0c,
		CBFE_OP_T_TO_BIT   = 5'h0d,
		CBFE_OP_FLAG_SET   = 5'h0e,
		CBFE_OP_FLAG_CLR   = 5'h0f,
		CBFE_OP_COPY       = 5'h10,
		CBFE_OP_PAIR_COPY  = 5'h11,
		CBFE_OP_LOAD_CONST = 5'h12,
		CBFE_OP_LD_X       = 5'h13,
		CBFE_OP_LD_X_INC   = 5'h14,
		CBFE_OP_LD_X_DEC   = 5'h15,
		CBFE_OP_LD_Y       = 5'h16,
		CBFE_OP_LD_Y_INC   = 5'h17,
		CBFE_OP_LD_Y_DEC   = 5'h18,
		CBFE_OP_LD_Y_DISP  = 5'h19
	} cbfe_op_e;

	typedef enum logic [0:0] {
		CBFE_ST_IDLE  = 1'b0,
		CBFE_ST_FINAL = 1'b1
	} cbfe_st_e;

	typedef struct packed {
		cbfe_st_e          st;
		cbfe_op_e          op;
		logic [4:0]        rd;
		logic [2:0]        bsel;
		logic [31:0][7:0]  rf;
		logic [7:0]        status_register;
		logic [15:0]       pc;
		logic              busy;
		logic              done;
		logic [15:0]       mem_addr;
		logic              mem_rd;
		logic [4:0]        io_addr;
		logic              io_rd;
		logic              io_wr;
		logic [7:0]        io_wdata;
		logic [7:0]        reg_val;
	} cbfe_state_s;

endpackage

// ### verif/cbfe_core_test.sv
`timescale 1ns/1ps

module cbfe_core_test;
	import cbfe_pkg::*;

	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmd_valid = 1'b0;
	cbfe_op_e    cmd_op = CBFE_OP_NOP;
	logic [4:0]  cmd_rd = 5'h00, cmd_rr = 5'h00, cmd_io = 5'h00, dbg_sel = 5'h00;
	logic [2:0]  cmd_bit = 3'h0;
	logic [7:0]  cmd_imm = 8'h00, mem_rdata = 8'h00, io_rdata = 8'h00;
	logic [6:0]  cmd_k = 7'h00;
	logic [5:0]  cmd_q = 6'h00;
	logic        busy, done, mem_rd, io_rd, io_wr;
	logic [15:0] pc, mem_addr;
	logic [7:0]  status_register, io_wdata, dbg_val;
	logic [4:0]  io_addr;
	int          miscompares = 0;
	int          comparisons = 0;
	logic [7:0]  s, dv, seen_wd;
	logic [15:0] p, jmp, px, py, a, seen_addr;
	logic [4:0]  seen_io;
	logic [8:0]  r;
	cbfe_op_e    sops[6] = '{CBFE_OP_SHL, CBFE_OP_SHR, CBFE_OP_ROL, CBFE_OP_ROR,
		CBFE_OP_ASR, CBFE_OP_SWAP};
	cbfe_op_e    bops[3] = '{CBFE_OP_BR_NO_OVF, CBFE_OP_BR_IRQ_ON, CBFE_OP_BR_IRQ_OFF};
	cbfe_op_e    lops[7] = '{CBFE_OP_LD_X_INC, CBFE_OP_LD_X, CBFE_OP_LD_X_DEC,
		CBFE_OP_LD_Y_DEC, CBFE_OP_LD_Y, CBFE_OP_LD_Y_INC, CBFE_OP_LD_Y_DISP};

	cbfe_core #(.PC_W(16)) cbfe_core_i (
		.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_rd(cmd_rd), .cmd_rr(cmd_rr), .cmd_bit(cmd_bit), .cmd_imm(cmd_imm),
		.cmd_k(cmd_k), .cmd_q(cmd_q), .cmd_io(cmd_io), .mem_rdata(mem_rdata),
		.io_rdata(io_rdata), .dbg_sel(dbg_sel), .busy(busy), .done(done), .pc(pc),
		.status_register(status_register), .mem_addr(mem_addr), .mem_rd(mem_rd), .io_addr(io_addr),
		.io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .dbg_val(dbg_val)
	);

	always #12.5 mclk = ~mclk;

	// ------------------------------------------------------------
	// Stimulus helpers
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Every op also checks pc and the whole status byte, so any stray flag write shows
	task automatic go(input cbfe_op_e op, input int lat);
		int n;
		seen_addr = 'x;
		seen_io = 'x;
		seen_wd = 'x;
		// One edge between requests, so valid is never lowered and raised in one step
		@(posedge mclk);
		#1;
		cmd_op = op;
		cmd_valid = 1'b1;
		@(posedge mclk);
		#1;
		cmd_valid = 1'b0;
		chk(busy, lat > 1);
		n = 1;
		while (done !== 1'b1 && n < 6) begin
			if (mem_rd === 1'b1) seen_addr = mem_addr;
			if (io_rd === 1'b1) seen_io = io_addr;
			@(posedge mclk);
			#1;
			n++;
		end
		if (io_wr === 1'b1) seen_wd = io_wdata;
		p = p + 16'h0001 + jmp;
		jmp = 16'h0000;
		chk(n, lat);
		chk(pc, p);
		chk(status_register, s);
	endtask

	// Readback is one cycle late, so two edges let the new value settle
	task automatic reg_is(input logic [4:0] rg, input logic [7:0] e);
		dbg_sel = rg;
		repeat (2) @(posedge mclk);
		#1;
		chk(dbg_val, e);
	endtask

	task automatic ldc(input logic [4:0] rg, input logic [7:0] v);
		cmd_rd = rg;
		cmd_imm = v;
		go(CBFE_OP_LOAD_CONST, 1);
	endtask

	task automatic setf(input logic [2:0] b, input logic v);
		cmd_bit = b;
		s[b] = v;
		go(v ? CBFE_OP_FLAG_SET : CBFE_OP_FLAG_CLR, 1);
	endtask

	function automatic logic [8:0] shx(cbfe_op_e op, logic [7:0] v, logic c);
		case (op)
			CBFE_OP_SHL: return {v[7], v[6:0], 1'b0};
			CBFE_OP_SHR: return {v[0], 1'b0, v[7:1]};
			CBFE_OP_ROL: return {v[7], v[6:0], c};
			CBFE_OP_ROR: return {v[0], c, v[7:1]};
			CBFE_OP_ASR: return {v[0], v[7], v[7:1]};
			default: return {c, v[3:0], v[7:4]};
		endcase
	endfunction

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		#(25 * 4000);
		miscompares++;
		stop_test();
	end

	initial begin
		s = 8'h00;
		p = 16'h0000;
		jmp = 16'h0000;
		px = 16'h00ff;
		py = 16'h0200;
		repeat (5) @(posedge mclk);
		#1;
		chk(pc, 16'h0000);
		chk(status_register, 8'h00);
		rst_n = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		for (int b = 0; b < 8; b++) setf(3'(b), 1'b1);
		for (int b = 0; b < 8; b++) setf(3'(b), 1'b0);
		ldc(16, 8'h81);
		ldc(17, 8'h3c);
		cmd_rd = 5'h01;
		cmd_rr = 5'h10;
		go(CBFE_OP_COPY, 1);
		reg_is(1, 8'h81);
		cmd_rd = 5'h02;
		go(CBFE_OP_PAIR_COPY, 1);
		reg_is(2, 8'h81);
		reg_is(3, 8'h3c);
		foreach (sops[i]) for (int j = 0; j < 2; j++) begin
			dv = j ? 8'h01 : 8'h81;
			ldc(20, dv);
			setf(3'h0, j == 0);
			r = shx(sops[i], dv, s[0]);
			if (sops[i] != CBFE_OP_SWAP) s[3:0] = {r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
			go(sops[i], 1);
			reg_is(20, r[7:0]);
		end
		ldc(20, 8'h81);
		cmd_rr = 5'h14;
		cmd_bit = 3'h7;
		s[6] = 1'b1;
		go(CBFE_OP_BIT_TO_T, 1);
		ldc(21, 8'h00);
		cmd_bit = 3'h3;
		go(CBFE_OP_T_TO_BIT, 1);
		reg_is(21, 8'h08);
		cmd_rd = 5'h14;
		cmd_bit = 3'h1;
		s[6] = 1'b0;
		go(CBFE_OP_BIT_TO_T, 1);
		// Taken branches go back by one, untaken ones carry a forward offset
		foreach (bops[i]) for (int j = 0; j < 2; j++) begin
			setf(i == 0 ? 3'h3 : 3'h7, (i == 1) ^ (j == 1));
			cmd_k = j ? 7'h05 : 7'h7e;
			jmp = j ? 16'h0000 : 16'hfffe;
			go(bops[i], j ? 1 : 2);
		end
		io_rdata = 8'h5a;
		for (int j = 0; j < 2; j++) begin
			cmd_io = j ? 5'h00 : 5'h1f;
			cmd_bit = j ? 3'h1 : 3'h7;
			go(j ? CBFE_OP_IO_CLR : CBFE_OP_IO_SET, 2);
			chk(seen_io, cmd_io);
			chk(seen_wd, j ? 8'h58 : 8'hda);
		end
		// Pointers start next to a byte boundary so carries into the high byte show
		ldc(26, 8'hff);
		ldc(27, 8'h00);
		ldc(28, 8'h00);
		ldc(29, 8'h02);
		cmd_q = 6'h3f;
		foreach (lops[i]) begin
			dv = 8'h30 + 8'(i);
			mem_rdata = dv;
			cmd_rd = 5'h10;
			if (i == 2) px = px - 16'h0001;
			if (i == 3) py = py - 16'h0001;
			a = (i < 3) ? px : py;
			if (i == 6) a = py + 16'h003f;
			go(lops[i], 2);
			chk(seen_addr, a);
			if (i == 0) px = px + 16'h0001;
			if (i == 5) py = py + 16'h0001;
			reg_is(16, dv);
			reg_is(26, px[7:0]);
			reg_is(27, px[15:8]);
			reg_is(28, py[7:0]);
			reg_is(29, py[15:8]);
		end
		stop_test();
	end

endmodule // cbfe_core_test
